// *** inc/csc_pkg.sv ***
// Shared constants and types of the status and core-control block
package csc_pkg;

  // Status register field positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_OV = 2;
  localparam int SR_N = 3;
  localparam int SR_RA = 4;
  localparam int SR_IPL = 5;
  localparam int SR_DC = 8;
  localparam int SR_USED_W = 9;
  // Core control field positions
  localparam int CC_PSV = 2;
  localparam int CC_PRIORITY_LEVEL_MSB = 3;
  localparam int CC_LOW_W = 2;
  localparam int CC_HIGH_W = 12;

  // Reset values
  localparam logic [15:0] W_RST = 16'h0000;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [22:0] PC_RST = 23'h000000;

  // Widths and sizes
  localparam int DATA_W = 16;
  localparam int PC_W = 23;
  localparam int INSN_W = 24;
  localparam int NREGS = 16;
  localparam int IDX_W = 4;
  localparam logic [3:0] SP_IDX = 4'hF;
  localparam logic [3:0] QUO_IDX = 4'h0;
  localparam logic [3:0] REM_IDX = 4'h1;
  localparam logic [3:0] PAIR_HI = 4'h1;
  localparam int PAGE_W = 8;
  localparam int WIN_OFS_W = 15;
  localparam int WIN_BIT = 15;
  localparam int RPT_W = 14;
  localparam int MUL_W = 17;
  localparam logic [15:0] SHIFT_MAX = 16'h0010;
  localparam logic [2:0] IPL_TOP = 3'h7;
  localparam logic [22:0] PC_STEP = 23'h000002;

  // Divider timing: one load step, one step per divisor bit, one idle step, then write-back
  localparam int DIV_CYCLES = 19;
  localparam logic [4:0] DIV_LOAD = 5'h00;
  localparam logic [4:0] DIV_BITS = 5'h10;
  localparam logic [4:0] DIV_LAST = 5'(DIV_CYCLES - 1);

  // Clock and multi-cycle instruction timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int MULTI_EXTRA_NS = 100;
  localparam int MULTI_EXTRA_CYC = (MULTI_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    OP_NONE, OP_MOVI, OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_MUL, OP_SHIFT, OP_DIV
  } csc_op_t;

  typedef enum logic [1:0] {INS_NORMAL, INS_FLOW, INS_DMOVE, INS_TABLE} csc_kind_t;

  typedef enum logic [1:0] {LP_IDLE, LP_RUN, LP_HELD} csc_loop_t;

  typedef struct packed {
    logic valid;
    csc_kind_t kind;
    csc_op_t op;
    logic byte_mode;
    logic sign_a;
    logic sign_b;
    logic [IDX_W-1:0] ra;
    logic [IDX_W-1:0] rb;
    logic [IDX_W-1:0] rd;
    logic [DATA_W-1:0] imm;
    logic [PC_W-1:0] target;
  } csc_insn_t;

  typedef struct packed {
    logic sr_we;
    logic cc_we;
    logic page_we;
    logic [DATA_W-1:0] data;
  } csc_regwr_t;

  typedef struct packed {
    logic [DATA_W-1:0] res;
    logic c;
    logic dc;
    logic z;
    logic n;
    logic ov;
  } csc_flags_t;

endpackage : csc_pkg

// *** verilog/csc_alu_flags.sv ***
// Adder and subtractor with carry, half-carry, zero, negative and overflow flags
module csc_alu_flags (
  input wire logic [15:0] a_i, // First operand
  input wire logic [15:0] b_i, // Second operand
  input wire logic sub_i, // High for a minus b
  input wire logic byte_i, // High for a byte-sized operation
  output csc_pkg::csc_flags_t flags_o // Result and flags
);

  logic [15:0] bb;
  logic [4:0] nib;
  logic [8:0] lo;
  logic [16:0] sum;

  // Subtract as a plus not b plus one, so carry out means no borrow
  assign bb = sub_i ? ~b_i : b_i;
  assign nib = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, sub_i};
  assign lo = {1'b0, a_i[7:0]} + {1'b0, bb[7:0]} + {8'h00, sub_i};
  assign sum = {1'b0, a_i} + {1'b0, bb} + {16'h0000, sub_i};

  always_comb
  begin
    if (byte_i)
    begin
      flags_o.res = {a_i[15:8], lo[7:0]};
      flags_o.c = lo[8];
      flags_o.dc = nib[4];
      flags_o.n = lo[7];
      flags_o.z = (lo[7:0] == 8'h00);
      flags_o.ov = (a_i[7] == bb[7]) && (lo[7] != a_i[7]);
    end
    else
    begin
      flags_o.res = sum[15:0];
      flags_o.c = sum[16];
      flags_o.dc = lo[8];
      flags_o.n = sum[15];
      flags_o.z = (sum[15:0] == 16'h0000);
      flags_o.ov = (a_i[15] == bb[15]) && (sum[15] != a_i[15]);
    end
  end

endmodule : csc_alu_flags

// *** verilog/csc_core.sv ***
// CPU status flags, core control, working registers and execution datapath
//
// Contract
// - Status bits 15 to 9 read zero
// - Half carry from bit 3 byte, 7 word
// - Three priority bits give level 0 to 7
// - Priority msb above low bits; set disables user
// - Low priority bits read-only when nesting disabled
// - Loop active bit read-only, one during loop
// - Negative flag follows result sign
// - Overflow flag on signed sign change
// - Zero flag from latest affecting operation
// - Carry flag from carry out of msb
// - Priority msb clear-only from software
// - Program window enable resets to zero
// - Upper data half maps to program page
// - Data space is 32K words, 64 Kbytes
// - 23-bit program counter, 24-bit instructions
// - Single cycle except flow, double move, table
// - Single-instruction loop, no overhead, interruptible
// - Sixteen 16-bit working registers, last is stack
// - Divide runs in loop, 19 cycles, interruptible
// - 17 by 17 signed/unsigned/mixed multiplier
// - Shift up to 16 bits in one cycle
// - Carry and half carry borrow on subtract
module csc_core (
  input wire logic clock_i, // Instruction clock
  input wire logic resetn_i, // Asynchronous reset, active low
  input wire csc_pkg::csc_insn_t insn_i, // Decoded instruction
  input wire csc_pkg::csc_regwr_t regwr_i, // Software register write
  input wire logic nesting_disable_i, // Nesting disable control bit
  input wire logic rpt_start_i, // Start a single-instruction loop
  input wire logic [13:0] rpt_count_i, // Extra repetitions of the loop
  input wire logic irq_pending_i, // Interrupt wants the CPU
  input wire logic irq_return_i, // Interrupt handler has returned
  input wire logic hw_ipl_we_i, // Interrupt logic loads priority
  input wire logic [3:0] hw_ipl_i, // Priority level from interrupt logic
  input wire logic [15:0] data_addr_i, // Data space byte address
  output logic [15:0] sr_o, // Status register read value
  output logic [15:0] core_control_o, // Core control read value
  output logic [7:0] page_o, // Program window page
  output logic [22:0] pc_o, // Program counter
  output logic [15:0] result_o, // Last datapath result
  output logic [15:0] sp_o, // Stack pointer register
  output logic insn_ready_o, // An instruction can be taken this cycle
  output logic irq_ack_o, // Loop paused for an interrupt, pulse
  output logic user_irq_off_o, // User interrupts disabled
  output logic prog_sel_o, // Address falls in the program window
  output logic [22:0] prog_addr_o, // Program space byte address
  output logic [14:0] data_word_o // Data space word index
);

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
    logic ra;
    logic [2:0] ipl_lo;
    logic priority_level_msb;
    logic program_window_enable;
    logic [7:0] page;
    logic [22:0] pc;
    logic [15:0][15:0] w;
    csc_pkg::csc_loop_t loop;
    logic [13:0] rpt_cnt;
    logic [4:0] div_step;
    logic [16:0] div_rem;
    logic [31:0] div_quo;
    logic stall;
    logic [15:0] result;
    logic ready;
    logic ack;
    logic uoff;
    logic psel;
    logic [22:0] paddr;
    logic [14:0] dword;
  } csc_state_t;

  csc_state_t q;
  csc_state_t d;

  logic [15:0] opa;
  logic [15:0] opb;
  logic go;
  logic arith_sub;
  csc_pkg::csc_flags_t af;
  logic signed [16:0] mul_a;
  logic signed [16:0] mul_b;
  logic signed [33:0] prod;
  logic [15:0] sh_mag;
  logic [15:0] sh_res;
  logic [16:0] div_sh;
  logic [15:0] logic_res;
  logic [3:0] pair_lo;
  logic [3:0] pair_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Operand fetch and arithmetic

  assign opa = q.w[insn_i.ra];
  assign opb = q.w[insn_i.rb];
  assign go = insn_i.valid && q.ready;
  assign arith_sub = (insn_i.op == csc_pkg::OP_SUB);
  assign pair_lo = insn_i.rd & ~csc_pkg::PAIR_HI;
  assign pair_hi = insn_i.rd | csc_pkg::PAIR_HI;

  csc_alu_flags u_flags (
    .a_i(opa),
    .b_i(opb),
    .sub_i(arith_sub),
    .byte_i(insn_i.byte_mode),
    .flags_o(af)
  );

  // Seventeenth bit extends the sign only for a signed operand
  assign mul_a = {insn_i.sign_a & opa[15], opa};
  assign mul_b = {insn_i.sign_b & opb[15], opb};
  assign prod = mul_a * mul_b;

  // Positive amount shifts right, negative left, clamped to the width
  always_comb
  begin
    sh_mag = opb[15] ? 16'(-opb) : opb;
    if (sh_mag > csc_pkg::SHIFT_MAX)
    begin
      sh_mag = csc_pkg::SHIFT_MAX;
    end
    if (opb[15])
    begin
      sh_res = opa << sh_mag;
    end
    else if (insn_i.sign_a)
    begin
      sh_res = 16'($signed(opa) >>> sh_mag);
    end
    else
    begin
      sh_res = opa >> sh_mag;
    end
  end

  always_comb
  begin
    case (insn_i.op)
      csc_pkg::OP_AND: logic_res = opa & opb;
      csc_pkg::OP_IOR: logic_res = opa | opb;
      csc_pkg::OP_XOR: logic_res = opa ^ opb;
      default: logic_res = sh_res;
    endcase
  end

  assign div_sh = {q.div_rem[15:0], q.div_quo[31]};

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    d = q;
    d.ack = 1'b0;
    if (go)
    begin
      case (insn_i.op)
        csc_pkg::OP_MOVI:
        begin
          d.w[insn_i.rd] = insn_i.imm;
          d.result = insn_i.imm;
        end
        csc_pkg::OP_ADD, csc_pkg::OP_SUB:
        begin
          d.w[insn_i.rd] = af.res;
          d.result = af.res;
          d.c = af.c;
          d.dc = af.dc;
          d.n = af.n;
          d.ov = af.ov;
          d.z = af.z;
        end
        csc_pkg::OP_AND, csc_pkg::OP_IOR, csc_pkg::OP_XOR, csc_pkg::OP_SHIFT:
        begin
          if (insn_i.byte_mode)
          begin
            d.w[insn_i.rd] = {opa[15:8], logic_res[7:0]};
            d.result = {opa[15:8], logic_res[7:0]};
            d.n = logic_res[7];
            d.z = (logic_res[7:0] == 8'h00);
          end
          else
          begin
            d.w[insn_i.rd] = logic_res;
            d.result = logic_res;
            d.n = logic_res[15];
            d.z = (logic_res == 16'h0000);
          end
        end
        csc_pkg::OP_MUL:
        begin
          d.w[pair_lo] = prod[15:0];
          d.w[pair_hi] = prod[31:16];
          d.result = prod[15:0];
        end
        csc_pkg::OP_DIV:
        begin
          // Partial quotient lives in flops, so a paused loop loses nothing
          if (q.div_step == csc_pkg::DIV_LOAD)
          begin
            d.div_rem = {1'b0, q.w[insn_i.ra | csc_pkg::PAIR_HI]};
            d.div_quo = {q.w[insn_i.ra & ~csc_pkg::PAIR_HI], 16'h0000};
          end
          else if (q.div_step <= csc_pkg::DIV_BITS)
          begin
            if (div_sh >= {1'b0, opb})
            begin
              d.div_rem = div_sh - {1'b0, opb};
              d.div_quo = {q.div_quo[30:0], 1'b1};
            end
            else
            begin
              d.div_rem = div_sh;
              d.div_quo = {q.div_quo[30:0], 1'b0};
            end
          end
          if (q.div_step == csc_pkg::DIV_LAST)
          begin
            d.w[csc_pkg::QUO_IDX] = q.div_quo[15:0];
            d.w[csc_pkg::REM_IDX] = q.div_rem[15:0];
            d.result = q.div_quo[15:0];
            d.div_step = csc_pkg::DIV_LOAD;
          end
          else
          begin
            d.div_step = q.div_step + 5'h01;
          end
        end
        default:
        begin
          d.result = q.result;
        end
      endcase

      // Program counter and multi-cycle instructions
      if ((q.loop == csc_pkg::LP_RUN) && (q.rpt_cnt != '0))
      begin
        d.rpt_cnt = q.rpt_cnt - 14'h0001;
      end
      else
      begin
        if (q.loop == csc_pkg::LP_RUN)
        begin
          d.loop = csc_pkg::LP_IDLE;
        end
        if (insn_i.kind == csc_pkg::INS_FLOW)
        begin
          d.pc = insn_i.target;
        end
        else
        begin
          d.pc = q.pc + csc_pkg::PC_STEP;
        end
      end
      d.stall = (insn_i.kind != csc_pkg::INS_NORMAL);
    end
    else
    begin
      d.stall = 1'b0;
    end

    // Loop control; the pause costs the loop nothing but the interrupt itself
    if ((q.loop == csc_pkg::LP_IDLE) && rpt_start_i)
    begin
      d.loop = csc_pkg::LP_RUN;
      d.rpt_cnt = rpt_count_i;
    end
    else if ((q.loop == csc_pkg::LP_RUN) && irq_pending_i)
    begin
      d.loop = csc_pkg::LP_HELD;
      d.ack = 1'b1;
    end
    else if ((q.loop == csc_pkg::LP_HELD) && irq_return_i)
    begin
      d.loop = csc_pkg::LP_RUN;
    end
    d.ra = (d.loop == csc_pkg::LP_RUN);

    // Software writes; the upper bits of the bus are dropped
    if (regwr_i.sr_we)
    begin
      d.dc = regwr_i.data[csc_pkg::SR_DC];
      d.n = regwr_i.data[csc_pkg::SR_N];
      d.ov = regwr_i.data[csc_pkg::SR_OV];
      d.z = regwr_i.data[csc_pkg::SR_Z];
      d.c = regwr_i.data[csc_pkg::SR_C];
      if (!nesting_disable_i)
      begin
        d.ipl_lo = regwr_i.data[csc_pkg::SR_IPL +: 3];
      end
    end
    if (regwr_i.cc_we)
    begin
      d.priority_level_msb = q.priority_level_msb & regwr_i.data[csc_pkg::CC_PRIORITY_LEVEL_MSB];
      d.program_window_enable = regwr_i.data[csc_pkg::CC_PSV];
    end
    if (regwr_i.page_we)
    begin
      d.page = regwr_i.data[csc_pkg::PAGE_W-1:0];
    end
    // Hardware priority load wins over a software clear in the same cycle
    if (hw_ipl_we_i)
    begin
      d.ipl_lo = hw_ipl_i[2:0];
      d.priority_level_msb = hw_ipl_i[3];
    end
    d.uoff = d.priority_level_msb || (d.ipl_lo == csc_pkg::IPL_TOP);

    d.ready = ~d.stall;
    // Window decode registered, so the map answers one cycle after the address
    d.psel = data_addr_i[csc_pkg::WIN_BIT] & q.program_window_enable;
    d.paddr = {q.page, data_addr_i[csc_pkg::WIN_OFS_W-1:0]};
    d.dword = data_addr_i[15:1];
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      q <= '0;
      q.page <= csc_pkg::PAGE_RST;
      q.pc <= csc_pkg::PC_RST;
      q.w <= {csc_pkg::NREGS{csc_pkg::W_RST}};
      q.loop <= csc_pkg::LP_IDLE;
      q.ready <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign sr_o = {7'h00, q.dc, q.ipl_lo, q.ra, q.n, q.ov, q.z, q.c};
  assign core_control_o = {12'h000, q.priority_level_msb, q.program_window_enable, 2'h0};
  assign page_o = q.page;
  assign pc_o = q.pc;
  assign result_o = q.result;
  assign sp_o = q.w[csc_pkg::SP_IDX];
  assign insn_ready_o = q.ready;
  assign irq_ack_o = q.ack;
  assign user_irq_off_o = q.uoff;
  assign prog_sel_o = q.psel;
  assign prog_addr_o = q.paddr;
  assign data_word_o = q.dword;

endmodule : csc_core

// *** sim/csc_core_checker.sv ***
// Port assertions for the status and core-control block
module csc_core_checker (
  input wire logic clock_i, // Instruction clock
  input wire logic resetn_i, // Reset, active low
  input wire csc_pkg::csc_insn_t insn_i, // Decoded instruction
  input wire csc_pkg::csc_regwr_t regwr_i, // Software register write
  input wire logic nesting_disable_i, // Nesting disable
  input wire logic rpt_start_i, // Loop start
  input wire logic irq_pending_i, // Interrupt request
  input wire logic hw_ipl_we_i, // Hardware priority load
  input wire logic [15:0] data_addr_i, // Data byte address
  input wire logic [15:0] sr_o, // Status register
  input wire logic [15:0] core_control_o, // Core control
  input wire logic [7:0] page_o, // Window page
  input wire logic [22:0] pc_o, // Program counter
  input wire logic insn_ready_o, // Instruction can be taken
  input wire logic irq_ack_o, // Loop paused
  input wire logic user_irq_off_o, // User interrupts off
  input wire logic prog_sel_o, // Window hit
  input wire logic [22:0] prog_addr_o, // Program address
  input wire logic [14:0] data_word_o // Word index
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  logic take;
  assign take = insn_i.valid & insn_ready_o;
  ////////////////////////////////////////////////////////////////////////////////
  AST_SR_HIGH_ZERO: assert property (sr_o[15:9] == 7'h00)
    else $error("status high bits not zero");
  AST_CC_UNUSED_ZERO: assert property ({core_control_o[15:4], core_control_o[1:0]} == 14'h0000)
    else $error("core control unused bits not zero");
  AST_USER_OFF: assert property (user_irq_off_o == ((&sr_o[7:5]) | core_control_o[3]))
    else $error("user interrupt disable wrong");
  AST_IPL_LOCKED: assert property (regwr_i.sr_we && nesting_disable_i && !hw_ipl_we_i
    |=> $stable(sr_o[7:5])) else $error("priority bits written while locked");
  AST_MSB_CLEAR_ONLY: assert property (!core_control_o[3] && !hw_ipl_we_i |=> !core_control_o[3])
    else $error("priority msb set by software");
  AST_WIN_SEL: assert property (prog_sel_o == $past(data_addr_i[15] & core_control_o[2]))
    else $error("window select wrong");
  AST_WIN_MAP: assert property (prog_addr_o == {$past(page_o), $past(data_addr_i[14:0])}
    && data_word_o == $past(data_addr_i[15:1])) else $error("address map wrong");
  AST_LOOP_PAUSE: assert property (sr_o[4] && irq_pending_i && !take
    |=> !sr_o[4] && irq_ack_o) else $error("loop did not pause");
  AST_MULTI_CYCLE: assert property (take && insn_i.kind != csc_pkg::INS_NORMAL
    |=> !insn_ready_o ##1 insn_ready_o) else $error("multi-cycle spacing wrong");
  AST_PC_STEP: assert property (take && insn_i.kind == csc_pkg::INS_NORMAL && !sr_o[4]
    && !rpt_start_i |=> pc_o == $past(pc_o) + csc_pkg::PC_STEP) else $error("pc step wrong");
  cover property (take && insn_i.kind != csc_pkg::INS_NORMAL);
  cover property (sr_o[4] && irq_pending_i);
  cover property (regwr_i.sr_we && nesting_disable_i);
endmodule : csc_core_checker

bind csc_core csc_core_checker chk (.clock_i(clock_i), .resetn_i(resetn_i), .insn_i(insn_i),
  .regwr_i(regwr_i), .nesting_disable_i(nesting_disable_i), .rpt_start_i(rpt_start_i),
  .irq_pending_i(irq_pending_i), .hw_ipl_we_i(hw_ipl_we_i), .data_addr_i(data_addr_i),
  .sr_o(sr_o), .core_control_o(core_control_o), .page_o(page_o), .pc_o(pc_o), .insn_ready_o(insn_ready_o),
  .irq_ack_o(irq_ack_o), .user_irq_off_o(user_irq_off_o), .prog_sel_o(prog_sel_o),
  .prog_addr_o(prog_addr_o), .data_word_o(data_word_o));

// *** sim/cpu_status_core_control_tb.sv ***
// Self-checking testbench of the status and core-control block
module cpu_status_core_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, resetn_i, nesting_disable_i, rpt_start_i, irq_pending_i, irq_return_i;
  logic hw_ipl_we_i, insn_ready_o, irq_ack_o, user_irq_off_o, prog_sel_o;
  csc_pkg::csc_insn_t insn_i;
  csc_pkg::csc_regwr_t regwr_i;
  logic [13:0] rpt_count_i;
  logic [3:0] hw_ipl_i;
  logic [15:0] data_addr_i, sr_o, core_control_o, result_o, sp_o, a, b, d;
  logic [7:0] page_o;
  logic [22:0] pc_o, prog_addr_o;
  logic [14:0] data_word_o;
  logic [31:0] e;
  logic [33:0] ct [8];
  logic [1:0] sg;
  csc_pkg::csc_op_t op;
  int num_errors, checks, cyc, seed, i, j;

  csc_core dut (.clock_i(clock_i), .resetn_i(resetn_i), .insn_i(insn_i), .regwr_i(regwr_i),
    .nesting_disable_i(nesting_disable_i), .rpt_start_i(rpt_start_i),
    .rpt_count_i(rpt_count_i), .irq_pending_i(irq_pending_i), .irq_return_i(irq_return_i),
    .hw_ipl_we_i(hw_ipl_we_i), .hw_ipl_i(hw_ipl_i), .data_addr_i(data_addr_i), .sr_o(sr_o),
    .core_control_o(core_control_o), .page_o(page_o), .pc_o(pc_o), .result_o(result_o), .sp_o(sp_o),
    .insn_ready_o(insn_ready_o), .irq_ack_o(irq_ack_o), .user_irq_off_o(user_irq_off_o),
    .prog_sel_o(prog_sel_o), .prog_addr_o(prog_addr_o), .data_word_o(data_word_o));

  initial
  begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task finish_test;
    if (num_errors == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  task chk(input logic [22:0] got, input logic [22:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task step;
    @(posedge clock_i);
    #10;
  endtask : step

  // Waits out a multi-cycle refusal before offering the next instruction
  task exec(input csc_pkg::csc_op_t op, input csc_pkg::csc_kind_t k, input logic bm,
    input logic [3:0] ra, input logic [3:0] rb, input logic [3:0] rd, input logic [15:0] imm);
    for (j = 0; j < 4 && insn_ready_o !== 1'b1; j++)
      step;
    insn_i = '0;
    insn_i.valid = 1'b1;
    insn_i.kind = k;
    insn_i.op = op;
    insn_i.byte_mode = bm;
    insn_i.ra = ra;
    insn_i.rb = rb;
    insn_i.rd = rd;
    insn_i.imm = imm;
    insn_i.sign_a = sg[1];
    insn_i.sign_b = sg[0];
    step;
    insn_i.valid = 1'b0;
  endtask : exec

  task wr(input logic [2:0] sel, input logic [15:0] v);
    regwr_i = {sel, v};
    step;
    regwr_i = '0;
  endtask : wr

  // Expected result and status image, priority and loop bits zero
  function logic [31:0] alu(input logic [15:0] a, input logic [15:0] b, input logic s,
    input logic bm);
    logic [16:0] r;
    logic [8:0] h;
    logic [15:0] x, res;
    logic c, dc, n, v, z;
    x = s ? ~b : b;
    if (bm)
    begin
      r = 17'(a[7:0]) + 17'(x[7:0]) + 17'(s);
      h = 9'(a[3:0]) + 9'(x[3:0]) + 9'(s);
      c = r[8];
      dc = h[4];
      res = {a[15:8], r[7:0]};
      n = r[7];
      v = (a[7] == x[7]) && (r[7] != a[7]);
      z = (res[7:0] == 8'h00);
    end
    else
    begin
      r = 17'(a) + 17'(x) + 17'(s);
      h = 9'(a[7:0]) + 9'(x[7:0]) + 9'(s);
      c = r[16];
      dc = h[8];
      res = r[15:0];
      n = r[15];
      v = (a[15] == x[15]) && (r[15] != a[15]);
      z = (res == 16'h0000);
    end
    return {res, 7'h00, dc, 4'h0, n, v, z, c};
  endfunction : alu

  // Expected shift: signed amount, positive right, clamped to 16 places
  function logic [15:0] shf(input logic [15:0] v, input logic [15:0] n, input logic ar);
    int k;
    k = n[15] ? 65536 - int'(n) : int'(n);
    if (k > 16)
      k = 16;
    if (n[15])
      return v << k;
    return ar ? 16'($signed(v) >>> k) : v >> k;
  endfunction : shf

  // Expected logic result; byte mode keeps the first operand's upper byte
  function logic [15:0] lop(input csc_pkg::csc_op_t o, input logic [15:0] x,
    input logic [15:0] y, input logic bm);
    logic [15:0] r;
    r = (o == csc_pkg::OP_AND) ? x & y : (o == csc_pkg::OP_IOR) ? x | y : x ^ y;
    return bm ? {x[15:8], r[7:0]} : r;
  endfunction : lop

  task arith(input logic [15:0] x, input logic [15:0] y, input logic s, input logic bm);
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h1, x);
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h2, y);
    exec(s ? csc_pkg::OP_SUB : csc_pkg::OP_ADD, csc_pkg::INS_NORMAL, bm, 4'h1, 4'h2, 4'h3, 16'h0);
    e = alu(x, y, s, bm);
    chk(23'(result_o), 23'(e[31:16]));
    chk(23'(sr_o), 23'(e[15:0]));
  endtask : arith

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      finish_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 34622;
    {resetn_i, nesting_disable_i, rpt_start_i, irq_pending_i, irq_return_i, hw_ipl_we_i} = '0;
    insn_i = '0;
    regwr_i = '0;
    sg = 2'b00;
    rpt_count_i = 14'h0000;
    hw_ipl_i = 4'h0;
    data_addr_i = 16'h0000;
    ct = '{{16'hFFFF, 16'h0001, 2'b00}, {16'h7FFF, 16'h0001, 2'b00}, {16'h000F, 16'h0001, 2'b01},
      {16'h127F, 16'h0001, 2'b01}, {16'h1234, 16'h1234, 2'b10}, {16'h0000, 16'h0001, 2'b10},
      {16'h8000, 16'h0001, 2'b10}, {16'h0010, 16'h0001, 2'b11}};
    repeat (2) @(posedge clock_i);
    #10 resetn_i = 1'b1;
    chk(23'(sr_o), 23'h0);
    chk(23'(core_control_o), 23'h0);
    for (i = 0; i < 8; i++)
      arith(ct[i][33:18], ct[i][17:2], ct[i][1], ct[i][0]);
    for (i = 0; i < 40; i++)
      arith(16'($random(seed)), 16'($random(seed)), 1'($random(seed)), 1'($random(seed)));
    wr(3'b100, 16'hFFFF);
    chk(23'(sr_o), 23'h01EF);
    nesting_disable_i = 1'b1;
    wr(3'b100, 16'h0000);
    chk(23'(sr_o), 23'h00E0);
    chk(23'(user_irq_off_o), 23'h1);
    nesting_disable_i = 1'b0;
    wr(3'b100, 16'h0000);
    hw_ipl_we_i = 1'b1;
    hw_ipl_i = 4'h8;
    step;
    hw_ipl_we_i = 1'b0;
    chk(23'(core_control_o), 23'h0008);
    chk(23'(user_irq_off_o), 23'h1);
    wr(3'b010, 16'hFFFF);
    chk(23'(core_control_o), 23'h000C);
    wr(3'b010, 16'h0004);
    chk(23'(core_control_o), 23'h0004);
    wr(3'b010, 16'hFFFF);
    chk(23'(core_control_o), 23'h0004);
    for (i = 0; i < 16; i++)
    begin
      b = 16'($random(seed)) & 16'h0004;
      a = 16'($random(seed));
      d = 16'($random(seed));
      wr(3'b010, b);
      wr(3'b001, a);
      data_addr_i = d;
      step;
      chk(23'(prog_sel_o), 23'(d[15] & b[2]));
      chk(prog_addr_o, {a[7:0], d[14:0]});
      chk(23'(data_word_o), 23'(d[15:1]));
      chk(23'(page_o), 23'(a[7:0]));
    end
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'hF, a);
    chk(23'(sp_o), 23'(a));
    for (i = 1; i < 4; i++)
    begin
      exec(csc_pkg::OP_NONE, csc_pkg::csc_kind_t'(i), 1'b0, 4'h0, 4'h0, 4'h0, 16'h0);
      chk(23'(insn_ready_o), 23'h0);
      step;
      chk(23'(insn_ready_o), 23'h1);
    end
    // Jump to zero, then two multi-cycle steps of one word each
    chk(pc_o, 23'h000004);
    d = 16'($random(seed)) | 16'h0100;
    a = 16'($random(seed)) % d;
    b = 16'($random(seed));
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h0, b);
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h1, a);
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h2, d);
    exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h4, 16'h0000);
    rpt_count_i = 14'h0012;
    rpt_start_i = 1'b1;
    step;
    rpt_start_i = 1'b0;
    chk(23'(sr_o[4]), 23'h1);
    for (i = 0; i < 19; i++)
    begin
      exec(csc_pkg::OP_DIV, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h2, 4'h0, 16'h0);
      if (i == 6)
      begin
        irq_pending_i = 1'b1;
        step;
        irq_pending_i = 1'b0;
        chk(23'(irq_ack_o), 23'h1);
        chk(23'(sr_o[4]), 23'h0);
        irq_return_i = 1'b1;
        step;
        irq_return_i = 1'b0;
        chk(23'(sr_o[4]), 23'h1);
      end
    end
    chk(23'(sr_o[4]), 23'h0);
    e = {a, b};
    exec(csc_pkg::OP_ADD, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h4, 4'h5, 16'h0);
    chk(23'(result_o), 23'(e / 32'(d)));
    exec(csc_pkg::OP_ADD, csc_pkg::INS_NORMAL, 1'b0, 4'h1, 4'h4, 4'h5, 16'h0);
    chk(23'(result_o), 23'(e % 32'(d)));
    // Multiplier signs, shifter clamp and logic ops, with a clamp corner first
    for (i = 0; i < 16; i++)
    begin
      a = 16'($random(seed));
      b = 16'($random(seed));
      d = (i == 0) ? 16'h8000 : 16'($random(seed)) % 16'h0023 - 16'h0011;
      sg = 2'($random(seed));
      op = csc_pkg::csc_op_t'(csc_pkg::OP_AND + i % 3);
      exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h1, a);
      exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h2, b);
      exec(csc_pkg::OP_MOVI, csc_pkg::INS_NORMAL, 1'b0, 4'h0, 4'h0, 4'h3, d);
      exec(csc_pkg::OP_MUL, csc_pkg::INS_NORMAL, 1'b0, 4'h1, 4'h2, 4'hE, 16'h0);
      e = (sg[1] ? 32'($signed(a)) : 32'(a)) * (sg[0] ? 32'($signed(b)) : 32'(b));
      chk(23'(result_o), 23'(e[15:0]));
      chk(23'(sp_o), 23'(e[31:16]));
      exec(csc_pkg::OP_SHIFT, csc_pkg::INS_NORMAL, 1'b0, 4'h1, 4'h3, 4'h5, 16'h0);
      e[15:0] = shf(a, d, sg[1]);
      chk(23'(result_o), 23'(e[15:0]));
      chk(23'({sr_o[3], sr_o[1]}), 23'({e[15], e[15:0] == 16'h0000}));
      exec(op, csc_pkg::INS_NORMAL, sg[0], 4'h1, 4'h2, 4'h5, 16'h0);
      chk(23'(result_o), 23'(lop(op, a, b, sg[0])));
    end
    finish_test;
  end
endmodule : cpu_status_core_control_tb
